// ### design/dnc_consts.svh
// constants of the oscillator control block: offsets, fields, resets
// assumes inclusion by bare name from the package and the modules
`ifndef DNC_CONSTS_SVH
`define DNC_CONSTS_SVH
// datapath widths
`define DNC_ACC_W 28
`define DNC_PH_W 12
`define DNC_WORD_W 16
`define DNC_CTRL_W 14
`define DNC_CNT_W 4
`define DNC_LAST_BIT 4'hf
// register byte offsets
`define DNC_OFF_MODE 8'h00
`define DNC_OFF_CTRL 8'h04
`define DNC_OFF_FREQ_A 8'h08
`define DNC_OFF_FREQ_B 8'h0c
`define DNC_OFF_PH_A 8'h10
`define DNC_OFF_PH_B 8'h14
`define DNC_OFF_STATUS 8'h18
// control word field positions
`define DNC_CTRL_HALF 13
`define DNC_CTRL_FREQ_CHOICE_BIT 11
`define DNC_CTRL_PSEL 10
`define DNC_CTRL_PD 6
`define DNC_CTRL_OEN 5
`define DNC_CTRL_SRC 4
// serial word layout
`define DNC_KIND_HI 15
`define DNC_KIND_LO 14
`define DNC_PH_WHICH 13
// reset values and axi response codes
`define DNC_MODE_RST 1'h0
`define DNC_RESP_OKAY 2'h0
`define DNC_RESP_SLVERR 2'h2
`endif

// ### design/dnc_pkg.sv
// types shared by the oscillator control modules
// assumes the constants header is on the include path
package dnc_pkg;
  `include "dnc_consts.svh"

  typedef enum logic [1:0] {
    DNC_K_CTRL = 2'b00,
    DNC_K_FREQ_A = 2'b01,
    DNC_K_FREQ_B = 2'b10,
    DNC_K_PHASE = 2'b11
  } dnc_kind_t;

  typedef struct packed {
    logic [`DNC_WORD_W-1:0] shift;
    logic [`DNC_CNT_W-1:0] cnt;
    logic [`DNC_WORD_W-1:0] word;
    logic tgl;
  } dnc_rx_t;
endpackage

// ### design/dnc_word_if.sv
// carries finished serial words from the link domain to the core
// word is stable whenever done_tgl is seen to change
`timescale 1ns/100ps
interface dnc_word_if;
  logic [15:0] word;
  logic done_tgl;
  modport src (output word, output done_tgl);
  modport dst (input word, input done_tgl);
endinterface

// ### design/dnc_sync.sv
// two flip-flop level synchroniser, one lane per bit
// assumes inputs from pins or another clock domain
`timescale 1ns/100ps
module dnc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } dnc_sync_t;
  dnc_sync_t q, d;

  always_comb begin
    d.s1 = async_in;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_out = q.s2;
endmodule

// ### design/dnc_serial_rx.sv
// serial word receiver, runs on the falling edge of the link clock
// assumes frame sync meets setup to the falling edge it qualifies
// limitation: a cut word is only dropped once a falling edge sees
// frame sync high, so a host that stops the clock must give one
`timescale 1ns/100ps
module dnc_serial_rx
  import dnc_pkg::*;
(
  // link
  input wire logic sclk,
  input wire logic reset,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  // finished words
  dnc_word_if.src out
);
  dnc_rx_t q, d;

  always_comb begin
    d = q;
    if (frame_sync_n) begin
      d.cnt = '0;
    end else begin
      d.shift = {q.shift[`DNC_WORD_W-2:0], serial_data_in};
      d.cnt = q.cnt + 4'h1;
      if (q.cnt == `DNC_LAST_BIT) begin
        // word held until the next one, long enough for the core
        d.word = {q.shift[`DNC_WORD_W-2:0], serial_data_in};
        d.tgl = ~q.tgl;
      end
    end
  end

  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out.word = q.word;
  assign out.done_tgl = q.tgl;

  chk_word_len: assert property (
    @(negedge sclk) disable iff (reset)
    (!frame_sync_n && q.cnt == `DNC_LAST_BIT) |=> (q.tgl != $past(q.tgl))
  ) else $error("word not finished on sixteenth edge");

  chk_frame_reset: assert property (
    @(negedge sclk) disable iff (reset)
    frame_sync_n |=> (q.cnt == 4'h0 && $stable(q.tgl))
  ) else $error("frame sync high did not restart the word");
endmodule

// ### design/dnc_top.sv
// oscillator control block: serial loading, accumulator, select pins
// assumes an axi4-lite master on core_clk and a host on the serial link
//
// Overview of operation
// - frequency choice chooses which stored frequency word steps the accumulator
// - phase choice chooses which offset word is added to accumulator output
// - nco reset clears accumulation registers, output phase goes midscale; here phase_out is cleared to zero
// - nco reset leaves all serially loaded registers unchanged
// - sleep high keeps the converter powered down
// - sleep pin and powerdown control bit act alike
// - every serial transfer carries a sixteen bit word
// - serial data bits are sampled on the falling serial clock edge
// - frame sync low starts a new word
// - logic output drives only when its enable bit is one
// - source bit picks comparator or oscillator msb for logic output
// - output frequency is a binary fraction of the master clock
// - enable and source both one route comparator to logic output
// - 28 bit accumulator adds selected frequency word every cycle
// - 12 bit offset is added to the accumulator msbs
// - frame sync held low accepts each sixteen edges as a word
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
module dnc_top
  import dnc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // serial link
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic serial_data_in,
  // control pins
  input wire logic freq_choice_pin,
  input wire logic phase_choice_pin,
  input wire logic nco_reset,
  input wire logic sleep,
  input wire logic comparator_in,
  // outputs
  output logic [`DNC_PH_W-1:0] phase_out,
  output logic dac_powerdown,
  output logic logic_out,
  output logic logic_out_oe
);
  typedef struct packed {
    logic sel_by_pin;
    logic [`DNC_CTRL_W-1:0] ctrl;
    logic [`DNC_ACC_W-1:0] freq_a;
    logic [`DNC_ACC_W-1:0] freq_b;
    logic [`DNC_PH_W-1:0] ph_a;
    logic [`DNC_PH_W-1:0] ph_b;
    logic [`DNC_ACC_W-1:0] acc;
    logic [`DNC_PH_W-1:0] phase;
    logic f_sel;
    logic p_sel;
    logic lout;
    logic lout_oe;
    logic pd;
    logic tgl_seen;
    logic [15:0] words;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } dnc_top_t;

  dnc_top_t q, d;
  dnc_word_if wif ();
  logic [5:0] pins_s;
  logic fpin_s, ppin_s, nrst_s, sleep_s, comp_s, tgl_s;
  logic new_word;
  logic [15:0] w;
  logic [`DNC_ACC_W-1:0] inc;
  logic take_aw, take_w, take_ar;

  // register match, used by both channels
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a[7:0] == off);
  endfunction

  dnc_serial_rx u_rx (
    .sclk(sclk),
    .reset(reset),
    .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in),
    .out(wif.src)
  );

  // pins and the word toggle come from outside core_clk
  dnc_sync #(.W(6)) u_sync (
    .clk(core_clk),
    .reset(reset),
    .async_in({wif.done_tgl, comparator_in, sleep, nco_reset,
               phase_choice_pin, freq_choice_pin}),
    .sync_out(pins_s)
  );

  assign fpin_s = pins_s[0];
  assign ppin_s = pins_s[1];
  assign nrst_s = pins_s[2];
  assign sleep_s = pins_s[3];
  assign comp_s = pins_s[4];
  assign tgl_s = pins_s[5];
  assign new_word = (tgl_s != q.tgl_seen);
  assign w = wif.word;
  assign inc = q.f_sel ? q.freq_b : q.freq_a;

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign take_aw = s_axi_awvalid && s_axi_awready;
  assign take_w = s_axi_wvalid && s_axi_wready;
  assign take_ar = s_axi_arvalid && s_axi_arready;

  always_comb begin
    d = q;
    // serial loads land here whatever nco reset does
    if (new_word) begin
      d.tgl_seen = tgl_s;
      d.words = q.words + 16'h1;
      case (dnc_kind_t'(w[`DNC_KIND_HI:`DNC_KIND_LO]))
        DNC_K_CTRL: d.ctrl = w[`DNC_CTRL_W-1:0];
        DNC_K_FREQ_A: begin
          if (q.ctrl[`DNC_CTRL_HALF]) begin
            d.freq_a[27:14] = w[13:0];
          end else begin
            d.freq_a[13:0] = w[13:0];
          end
        end
        DNC_K_FREQ_B: begin
          if (q.ctrl[`DNC_CTRL_HALF]) begin
            d.freq_b[27:14] = w[13:0];
          end else begin
            d.freq_b[13:0] = w[13:0];
          end
        end
        DNC_K_PHASE: begin
          if (w[`DNC_PH_WHICH]) begin
            d.ph_b = w[`DNC_PH_W-1:0];
          end else begin
            d.ph_a = w[`DNC_PH_W-1:0];
          end
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    // pins are only trusted when software hands them the choice
    d.f_sel = q.sel_by_pin ? fpin_s : q.ctrl[`DNC_CTRL_FREQ_CHOICE_BIT];
    d.p_sel = q.sel_by_pin ? ppin_s : q.ctrl[`DNC_CTRL_PSEL];
    if (nrst_s) begin
      d.acc = '0;
      d.phase = '0;
    end else begin
      d.acc = q.acc + inc;
      d.phase = q.acc[`DNC_ACC_W-1:`DNC_ACC_W-`DNC_PH_W] +
                (q.p_sel ? q.ph_b : q.ph_a);
    end
    d.pd = sleep_s | q.ctrl[`DNC_CTRL_PD];
    d.lout_oe = q.ctrl[`DNC_CTRL_OEN];
    if (!q.ctrl[`DNC_CTRL_OEN]) begin
      d.lout = 1'b0;
    end else if (q.ctrl[`DNC_CTRL_SRC]) begin
      d.lout = comp_s;
    end else begin
      d.lout = q.acc[`DNC_ACC_W-1];
    end
    // write channel: address and data taken in either order
    if (take_aw) begin
      d.aw_got = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (take_w) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb0 = s_axi_wstrb[0];
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      if (hit(q.awaddr, `DNC_OFF_MODE)) begin
        d.bresp = `DNC_RESP_OKAY;
        if (q.wstrb0) begin
          d.sel_by_pin = q.wdata[0];
        end
      end else begin
        d.bresp = `DNC_RESP_SLVERR;
      end
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // read channel
    if (take_ar) begin
      d.rvalid = 1'b1;
      d.rresp = `DNC_RESP_OKAY;
      d.rdata = 32'h0;
      if (hit(s_axi_araddr, `DNC_OFF_MODE)) begin
        d.rdata[0] = q.sel_by_pin;
      end else if (hit(s_axi_araddr, `DNC_OFF_CTRL)) begin
        d.rdata[`DNC_CTRL_W-1:0] = q.ctrl;
      end else if (hit(s_axi_araddr, `DNC_OFF_FREQ_A)) begin
        d.rdata[`DNC_ACC_W-1:0] = q.freq_a;
      end else if (hit(s_axi_araddr, `DNC_OFF_FREQ_B)) begin
        d.rdata[`DNC_ACC_W-1:0] = q.freq_b;
      end else if (hit(s_axi_araddr, `DNC_OFF_PH_A)) begin
        d.rdata[`DNC_PH_W-1:0] = q.ph_a;
      end else if (hit(s_axi_araddr, `DNC_OFF_PH_B)) begin
        d.rdata[`DNC_PH_W-1:0] = q.ph_b;
      end else if (hit(s_axi_araddr, `DNC_OFF_STATUS)) begin
        d.rdata = {q.words, 13'h0, q.pd, q.p_sel, q.f_sel};
      end else begin
        d.rresp = `DNC_RESP_SLVERR;
      end
    end else if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
  end

  // system reset clears everything; the nco reset pin works in d
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
      q.sel_by_pin <= `DNC_MODE_RST;
    end else begin
      q <= d;
    end
  end

  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign phase_out = q.phase;
  assign dac_powerdown = q.pd;
  assign logic_out = q.lout;
  assign logic_out_oe = q.lout_oe;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_running;
    !nrst_s ##1 !nrst_s;
  endsequence

  chk_freq_step: assert property (
    s_running |-> q.acc == $past(q.acc) + $past(inc)
  ) else $error("accumulator did not add selected word");

  chk_phase_add: assert property (
    s_running |-> q.phase == $past(q.acc[27:16]) +
      ($past(q.p_sel) ? $past(q.ph_b) : $past(q.ph_a))
  ) else $error("phase offset sum wrong");

  chk_nco_clear: assert property (
    nrst_s |=> (q.acc == '0 && q.phase == '0)
  ) else $error("nco reset did not clear accumulation");

  chk_bank_keep: assert property (
    (nrst_s && !new_word) |=> ($stable(q.freq_a) && $stable(q.freq_b) &&
      $stable(q.ph_a) && $stable(q.ph_b) && $stable(q.ctrl))
  ) else $error("nco reset disturbed loaded words");

  chk_sleep_pd: assert property (
    sleep_s |=> dac_powerdown
  ) else $error("sleep did not power down converter");

  chk_bit_pd: assert property (
    ($past(q.ctrl[`DNC_CTRL_PD]) || $past(sleep_s)) == dac_powerdown
  ) else $error("powerdown does not follow pin and bit");

  chk_out_gate: assert property (
    !q.ctrl[`DNC_CTRL_OEN] [*2] |-> (!logic_out_oe && !logic_out)
  ) else $error("logic output drove while disabled");

  chk_out_comp: assert property (
    (q.ctrl[`DNC_CTRL_OEN] && q.ctrl[`DNC_CTRL_SRC]) |=>
      logic_out == $past(comp_s)
  ) else $error("comparator not routed to logic output");

  chk_out_msb: assert property (
    (q.ctrl[`DNC_CTRL_OEN] && !q.ctrl[`DNC_CTRL_SRC]) |=>
      logic_out == $past(q.acc[27])
  ) else $error("oscillator msb not routed to logic output");

  chk_sel_pin: assert property (
    q.sel_by_pin |=> q.f_sel == $past(fpin_s) && q.p_sel == $past(ppin_s)
  ) else $error("select pins not taken at clock edge");

  chk_ctrl_load: assert property (
    (new_word && w[`DNC_KIND_HI:`DNC_KIND_LO] == DNC_K_CTRL) |=>
      q.ctrl == $past(w[`DNC_CTRL_W-1:0])
  ) else $error("control word not loaded");

  chk_ph_load: assert property (
    (new_word && w[`DNC_KIND_HI:`DNC_KIND_LO] == DNC_K_PHASE &&
      !w[`DNC_PH_WHICH]) |=> q.ph_a == $past(w[`DNC_PH_W-1:0])
  ) else $error("phase offset a not loaded");

  chk_freq_half: assert property (
    (new_word && w[`DNC_KIND_HI:`DNC_KIND_LO] == DNC_K_FREQ_A &&
      q.ctrl[`DNC_CTRL_HALF]) |=> q.freq_a[27:14] == $past(w[13:0])
  ) else $error("upper frequency half not loaded");

  chk_word_count: assert property (
    new_word |=> q.words == $past(q.words) + 16'h1
  ) else $error("finished word not counted");

  chk_sel_bit: assert property (
    !q.sel_by_pin |=> q.f_sel == $past(q.ctrl[`DNC_CTRL_FREQ_CHOICE_BIT]) &&
      q.p_sel == $past(q.ctrl[`DNC_CTRL_PSEL])
  ) else $error("select bits not taken from control word");
endmodule

// ### dv/dnc_host_model.sv
// host side of the serial link: frames words onto the three wires
// assumes the caller waits for one frame to finish before the next
`timescale 1ns/100ps
module dnc_host_model (
  // serial link
  output logic sclk,
  output logic frame_sync_n,
  output logic serial_data_in
);
  initial begin
    sclk = 1'b1;
    frame_sync_n = 1'b1;
    serial_data_in = 1'b0;
  end

  // low n bits of w, msb first; n off a multiple of 16 aborts a word
  task automatic send(input logic [63:0] w, input int n);
    #3 frame_sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #15 sclk = 1'b0;
      #15 sclk = 1'b1;
    end
    #10 frame_sync_n = 1'b1;
    // a cut word needs one falling edge with frame sync high to clear it
    if (n % 16 != 0) begin
      #15 sclk = 1'b0;
      #15 sclk = 1'b1;
    end
    // no pull on the data line, so park it at the inverse of the last bit
    serial_data_in = ~serial_data_in;
  endtask
endmodule

// ### dv/tb_top.sv
// self-checking bench for the oscillator control block
// assumes the host model owns the link and axi runs on core_clk
`timescale 1ns/100ps
`include "dnc_consts.svh"
module tb_top;
  logic core_clk = 1'b0;
  logic reset = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic fpin = 1'b0, ppin = 1'b0, nrst = 1'b0, slp = 1'b0, cmp = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pd, lo, lo_oe;
  logic sclk, fsn, sdi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] phase_out, pa, pb, acc_hi;
  logic [27:0] fa, fb;
  logic [13:0] ctrl_v = 14'h0;
  logic [31:0] rnd = 32'h5b4d1e6a;
  int err_count = 0;
  int check_count = 0;
  int nwords = 0;

  always #5 core_clk = ~core_clk;

  dnc_host_model host (.sclk(sclk), .frame_sync_n(fsn),
    .serial_data_in(sdi));

  dnc_top dut (.core_clk(core_clk), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sclk(sclk), .frame_sync_n(fsn),
    .serial_data_in(sdi), .freq_choice_pin(fpin),
    .phase_choice_pin(ppin), .nco_reset(nrst), .sleep(slp),
    .comparator_in(cmp), .phase_out(phase_out), .dac_powerdown(pd),
    .logic_out(lo), .logic_out_oe(lo_oe));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [31:0] m, input logic [1:0] er);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(rdata & m, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // words cross into the core a few cycles after the last falling edge
  task automatic sendw(input logic [63:0] w, input int n);
    host.send(w, n);
    nwords += n / 16;
    cyc(8);
  endtask

  task automatic load_f(input logic [1:0] k, input logic [27:0] f);
    sendw({2'b00, ctrl_v & 14'h1fff, k, f[13:0],
      2'b00, ctrl_v | 14'h2000, k, f[27:14]}, 64);
  endtask

  // one cycle of phase advance; phase_out is sampled mid-cycle
  task automatic step(input logic [11:0] s);
    logic [11:0] p0;
    @(negedge core_clk);
    p0 = phase_out;
    @(negedge core_clk);
    chk(12'(phase_out - p0), s);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    // a real rising edge, else the link side never sees reset
    reset <= 1'b1;
    cyc(3);
    reset <= 1'b0;
    rd(`DNC_OFF_MODE, 32'h0, 32'hffffffff, `DNC_RESP_OKAY);
    rd(8'h1c, 32'h0, 32'hffffffff, `DNC_RESP_SLVERR);
    wr(`DNC_OFF_FREQ_A, 32'h5, `DNC_RESP_SLVERR);
    rd(`DNC_OFF_FREQ_A, 32'h0, 32'hffffffff, `DNC_RESP_OKAY);
    done("registers");
    rnd = lfsr(rnd);
    pa = rnd[11:0];
    pb = rnd[27:16];
    sendw({48'h0, 2'b11, 1'b0, 1'b0, pa}, 16);
    sendw({48'h0, 2'b11, 1'b1, 1'b0, pb}, 16);
    wr(`DNC_OFF_MODE, 32'h1, `DNC_RESP_OKAY);
    cyc(6);
    chk({20'h0, phase_out}, {20'h0, pa});
    ppin <= 1'b1;
    cyc(6);
    chk({20'h0, phase_out}, {20'h0, pb});
    done("phase offsets");
    rnd = lfsr(rnd);
    fa = {rnd[11:0], 16'h0};
    fb = {rnd[23:12], 16'h0};
    load_f(2'b01, fa);
    load_f(2'b10, fb);
    step(fa[27:16]);
    fpin <= 1'b1;
    cyc(6);
    step(fb[27:16]);
    wr(`DNC_OFF_MODE, 32'h0, `DNC_RESP_OKAY);
    fpin <= 1'b0;
    ctrl_v = 14'h0800;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    step(fb[27:16]);
    ctrl_v = 14'h0;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    step(fa[27:16]);
    done("frequency words");
    nrst <= 1'b1;
    cyc(6);
    chk({20'h0, phase_out}, 32'h0);
    step(12'h0);
    rd(`DNC_OFF_FREQ_A, {4'h0, fa}, 32'hffffffff, `DNC_RESP_OKAY);
    rd(`DNC_OFF_PH_B, {20'h0, pb}, 32'hffffffff, `DNC_RESP_OKAY);
    nrst <= 1'b0;
    cyc(6);
    step(fa[27:16]);
    done("nco reset");
    slp <= 1'b1;
    cyc(6);
    chk({31'h0, pd}, 32'h1);
    slp <= 1'b0;
    cyc(6);
    chk({31'h0, pd}, 32'h0);
    ctrl_v = 14'h0040;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    chk({31'h0, pd}, 32'h1);
    done("powerdown");
    ctrl_v = 14'h0010;
    cmp <= 1'b1;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    chk({30'h0, lo_oe, lo}, 32'h0);
    ctrl_v = 14'h0030;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      cmp <= rnd[0];
      cyc(6);
      chk({30'h0, lo_oe, lo}, {30'h0, 1'b1, rnd[0]});
    end
    nrst <= 1'b1;
    cmp <= 1'b1;
    ctrl_v = 14'h0020;
    sendw({48'h0, 2'b00, ctrl_v}, 16);
    chk({30'h0, lo_oe, lo}, 32'h2);
    nrst <= 1'b0;
    cyc(6);
    for (int i = 0; i < 32; i++) begin
      @(negedge core_clk);
      acc_hi = 12'(phase_out - pa);
      chk({31'h0, lo}, {31'h0, acc_hi[11]});
    end
    done("logic output");
    sendw({56'h0, 8'ha5}, 8);
    sendw({48'h0, 2'b00, 14'h0}, 16);
    rd(`DNC_OFF_STATUS, {nwords[15:0], 16'h0}, 32'hffff0000,
      `DNC_RESP_OKAY);
    rd(`DNC_OFF_CTRL, 32'h0, 32'h00003fff, `DNC_RESP_OKAY);
    done("frame restart");
    give_verdict;
  end
endmodule
